// >>> shared/irq_pkg.sv
/*
 * Constants for the interrupt mask and flag controller: register indices,
 * field positions, writable masks, reset values, vector numbers and the
 * external pin sense encodings.
 * Assumes an AHB-Lite slave with 32-bit data, one register per word, at a
 * byte address of four times the register index.
 */
package irq_pkg;

    localparam int IDX_W = 6;
    localparam int REG_W = 8;

    localparam logic [IDX_W-1:0] IDX_SENSE     = 6'h35;
    localparam logic [IDX_W-1:0] IDX_TMR_FLAGS = 6'h38;
    localparam logic [IDX_W-1:0] IDX_TMR_MASK  = 6'h39;
    localparam logic [IDX_W-1:0] IDX_PIN_FLAGS = 6'h3A;
    localparam logic [IDX_W-1:0] IDX_PIN_MASK  = 6'h3B;
    localparam logic [IDX_W-1:0] IDX_STATUS    = 6'h3F;

    localparam int PIN_B_BIT  = 7;
    localparam int PIN_A_BIT  = 6;
    localparam int TB_OVF_BIT = 7;
    localparam int TB_CMP_BIT = 6;
    localparam int TB_CAP_BIT = 3;
    localparam int TA_OVF_BIT = 1;
    localparam int GIE_BIT    = 7;
    localparam int SENSE_A_LSB = 0;
    localparam int SENSE_B_LSB = 2;

    localparam logic [REG_W-1:0] PIN_RW_MASK   = 8'hC0;
    localparam logic [REG_W-1:0] TMR_RW_MASK   = 8'hCA;
    localparam logic [REG_W-1:0] SENSE_RW_MASK = 8'h0F;
    localparam logic [REG_W-1:0] REG_RESET     = 8'h00;

    typedef enum logic [1:0] {
        SENSE_LOW  = 2'b00,
        SENSE_ANY  = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } sense_mode_t;

    // Source order equals vector order, so vector = source index + 1.
    localparam int NSRC       = 6;
    localparam int SRC_PIN_A  = 0;
    localparam int SRC_PIN_B  = 1;
    localparam int SRC_TB_CAP = 2;
    localparam int SRC_TB_CMP = 3;
    localparam int SRC_TB_OVF = 4;
    localparam int SRC_TA_OVF = 5;

    localparam int VEC_W = 4;
    localparam logic [VEC_W-1:0] VEC_NONE = 4'h0;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// >>> shared/sense_if.sv
/*
 * Carrier between the controller and one external pin sense unit.
 * Assumes the controller drives the mode and the unit returns registered
 * event and level signals on the same clock.
 */
`timescale 1ns/1ps
interface sense_if;
    logic [1:0] mode;
    logic       edge_evt;
    logic       level_req;
    modport sensor (input mode, output edge_evt, output level_req);
    modport ctrl   (output mode, input edge_evt, input level_req);
endinterface

// >>> src/pin_sense.sv
/*
 * External pin sense unit: synchronises the pin, detects the selected
 * edge as a one-cycle event, and reports the low level as a request.
 * Assumes the pin is asynchronous to hclk and held longer than a period.
 */
`timescale 1ns/1ps
module pin_sense (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin_in,
    sense_if.sensor   sense
);
    import irq_pkg::*;

    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic       prev;
        logic [2:0] warm;
        logic       evt;
        logic       lvl;
    } sense_state_t;

    sense_state_t s_reg;
    sense_state_t s_next;

    always_comb begin
        s_next       = s_reg;
        s_next.sync1 = pin_in;
        s_next.sync2 = s_reg.sync1;
        s_next.prev  = s_reg.sync2;
        s_next.warm  = {s_reg.warm[1:0], 1'b1};
        // Edges are ignored until the pipeline holds real samples, so a
        // pin idling high gives no false rising edge after reset.
        unique case (sense_mode_t'(sense.mode))
            SENSE_LOW:  s_next.evt = 1'b0;
            SENSE_ANY:  s_next.evt = s_reg.sync2 ^ s_reg.prev;
            SENSE_FALL: s_next.evt = s_reg.prev & ~s_reg.sync2;
            SENSE_RISE: s_next.evt = ~s_reg.prev & s_reg.sync2;
        endcase
        s_next.evt = s_next.evt & s_reg.warm[2];
        // The level request lives only while the pin is low.
        s_next.lvl = (sense.mode == SENSE_LOW) & ~s_reg.sync2
                     & s_reg.warm[1];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sense.edge_evt  = s_reg.evt;
    assign sense.level_req = s_reg.lvl;

endmodule

// >>> src/irq_ctrl.sv
/*
 * Interrupt mask and flag controller with an AHB-Lite register slave.
 * Holds the enable masks, the pin and timer flags, the pin sense field and
 * the global enable, and offers the winning vector to the core.
 * Assumes the core pulses irq_take when it vectors on the offered request,
 * instr_done at each instruction completion and return_from_handler_exec on a return.
 */
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module irq_ctrl (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    input  wire logic                      ext_pin_a,
    input  wire logic                      ext_pin_b,
    input  wire logic                      tmr_b_overflow_evt,
    input  wire logic                      tmr_b_compare_evt,
    input  wire logic                      tmr_b_capture_evt,
    input  wire logic                      tmr_a_overflow_evt,
    input  wire logic                      instr_done,
    input  wire logic                      irq_take,
    input  wire logic                      return_from_handler_exec,
    output logic                           irq_req,
    output logic      [irq_pkg::VEC_W-1:0] irq_vector,
    output logic                           global_enable
);
    import irq_pkg::*;

    typedef struct packed {
        logic [REG_W-1:0] pin_mask;
        logic [REG_W-1:0] tmr_mask;
        logic [REG_W-1:0] pin_flags;
        logic [REG_W-1:0] tmr_flags;
        logic [REG_W-1:0] sense;
        logic             gie;
        logic             hold;
        logic             wr_pend;
        logic [IDX_W-1:0] wr_idx;
        logic [31:0]      rdata;
        logic             ready;
        logic             resp;
        logic             req;
        logic [VEC_W-1:0] vec;
    } ctrl_state_t;

    ctrl_state_t s_reg;
    ctrl_state_t s_next;

    sense_if sense_a ();
    sense_if sense_b ();

    assign sense_a.mode = s_reg.sense[SENSE_A_LSB +: 2];
    assign sense_b.mode = s_reg.sense[SENSE_B_LSB +: 2];

    pin_sense u_sense_a (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin_in  (ext_pin_a),
        .sense   (sense_a)
    );

    pin_sense u_sense_b (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin_in  (ext_pin_b),
        .sense   (sense_b)
    );

    // Lowest source index, hence lowest vector address, wins.
    function automatic logic [VEC_W-1:0] pick_vector(
        input logic [NSRC-1:0] pend
    );
        logic [VEC_W-1:0] v;
        v = VEC_NONE;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                v = VEC_W'(i + 1);
            end
        end
        return v;
    endfunction

    function automatic logic [NSRC-1:0] source_of(
        input logic [VEC_W-1:0] vec
    );
        logic [NSRC-1:0] oh;
        oh = '0;
        for (int i = 0; i < NSRC; i++) begin
            if (vec == VEC_W'(i + 1)) begin
                oh[i] = 1'b1;
            end
        end
        return oh;
    endfunction

    function automatic logic addr_mapped(input logic [31:0] a);
        return (a[31:IDX_W+2] == '0) && (a[1:0] == 2'b00);
    endfunction

    logic [NSRC-1:0]  taken_src;
    logic [REG_W-1:0] pin_set;
    logic [REG_W-1:0] tmr_set;
    logic [REG_W-1:0] pin_clr;
    logic [REG_W-1:0] tmr_clr;
    logic [REG_W-1:0] wbyte;
    logic [NSRC-1:0]  pend;
    logic [IDX_W-1:0] a_idx;
    logic             a_valid;

    always_comb begin
        s_next    = s_reg;
        taken_src = '0;
        pin_set   = '0;
        tmr_set   = '0;
        pin_clr   = '0;
        tmr_clr   = '0;
        pend      = '0;
        wbyte     = hwdata[REG_W-1:0];
        a_idx     = haddr[IDX_W+1:2];
        a_valid   = hsel && hready && htrans[1];

        s_next.ready = 1'b1;
        s_next.resp  = 1'b0;

        // Hardware clears only the flag of the vector the core took.
        if (irq_take) begin
            taken_src = source_of(s_reg.vec);
        end
        pin_clr[PIN_A_BIT]  = taken_src[SRC_PIN_A];
        pin_clr[PIN_B_BIT]  = taken_src[SRC_PIN_B];
        tmr_clr[TB_CAP_BIT] = taken_src[SRC_TB_CAP];
        tmr_clr[TB_CMP_BIT] = taken_src[SRC_TB_CMP];
        tmr_clr[TB_OVF_BIT] = taken_src[SRC_TB_OVF];
        tmr_clr[TA_OVF_BIT] = taken_src[SRC_TA_OVF];

        // Data phase of a write accepted in the previous cycle.
        if (s_reg.wr_pend) begin
            unique case (s_reg.wr_idx)
                IDX_PIN_MASK: begin
                    s_next.pin_mask = wbyte & PIN_RW_MASK;
                end
                IDX_TMR_MASK: begin
                    s_next.tmr_mask = wbyte & TMR_RW_MASK;
                end
                IDX_SENSE: begin
                    s_next.sense = wbyte & SENSE_RW_MASK;
                end
                IDX_STATUS: begin
                    s_next.gie = wbyte[GIE_BIT];
                end
                IDX_PIN_FLAGS: begin
                    pin_clr = pin_clr | (wbyte & PIN_RW_MASK);
                end
                IDX_TMR_FLAGS: begin
                    tmr_clr = tmr_clr | (wbyte & TMR_RW_MASK);
                end
                default: begin
                end
            endcase
        end

        // Flags latch whatever the masks say; pin events come from the
        // synchronised pin itself, so driving the pin as an output works.
        pin_set[PIN_A_BIT]  = sense_a.edge_evt;
        pin_set[PIN_B_BIT]  = sense_b.edge_evt;
        tmr_set[TB_OVF_BIT] = tmr_b_overflow_evt;
        tmr_set[TB_CMP_BIT] = tmr_b_compare_evt;
        tmr_set[TB_CAP_BIT] = tmr_b_capture_evt;
        tmr_set[TA_OVF_BIT] = tmr_a_overflow_evt;

        // A new event in the clearing cycle survives the clear.
        s_next.pin_flags = ((s_reg.pin_flags & ~pin_clr) | pin_set)
                           & PIN_RW_MASK;
        s_next.tmr_flags = ((s_reg.tmr_flags & ~tmr_clr) | tmr_set)
                           & TMR_RW_MASK;

        // Return re-arms global enable but holds requests for one more
        // completed instruction.
        if (return_from_handler_exec) begin
            s_next.gie  = 1'b1;
            s_next.hold = 1'b1;
        end else if (instr_done) begin
            s_next.hold = 1'b0;
        end
        // Taking wins over a software write in the same cycle.
        if (irq_take) begin
            s_next.gie = 1'b0;
        end

        // Address phase: decode and prepare read data for the data phase.
        if (a_valid) begin
            s_next.wr_pend = hwrite && addr_mapped(haddr);
            s_next.wr_idx  = a_idx;
            s_next.rdata   = '0;
            if (!hwrite && addr_mapped(haddr)) begin
                unique case (a_idx)
                    IDX_PIN_MASK: begin
                        s_next.rdata[REG_W-1:0] = s_next.pin_mask;
                    end
                    IDX_TMR_MASK: begin
                        s_next.rdata[REG_W-1:0] = s_next.tmr_mask;
                    end
                    IDX_PIN_FLAGS: begin
                        s_next.rdata[REG_W-1:0] = s_next.pin_flags;
                    end
                    IDX_TMR_FLAGS: begin
                        s_next.rdata[REG_W-1:0] = s_next.tmr_flags;
                    end
                    IDX_SENSE: begin
                        s_next.rdata[REG_W-1:0] = s_next.sense;
                    end
                    IDX_STATUS: begin
                        s_next.rdata[GIE_BIT] = s_next.gie;
                    end
                    default: begin
                    end
                endcase
            end
        end else begin
            s_next.wr_pend = 1'b0;
        end

        // A level request counts only while the pin stays low, without a
        // flag behind it.
        pend[SRC_PIN_A] = s_next.pin_mask[PIN_A_BIT]
                          & (s_next.pin_flags[PIN_A_BIT]
                             | sense_a.level_req);
        pend[SRC_PIN_B] = s_next.pin_mask[PIN_B_BIT]
                          & (s_next.pin_flags[PIN_B_BIT]
                             | sense_b.level_req);
        pend[SRC_TB_CAP] = s_next.tmr_mask[TB_CAP_BIT]
                           & s_next.tmr_flags[TB_CAP_BIT];
        pend[SRC_TB_CMP] = s_next.tmr_mask[TB_CMP_BIT]
                           & s_next.tmr_flags[TB_CMP_BIT];
        pend[SRC_TB_OVF] = s_next.tmr_mask[TB_OVF_BIT]
                           & s_next.tmr_flags[TB_OVF_BIT];
        pend[SRC_TA_OVF] = s_next.tmr_mask[TA_OVF_BIT]
                           & s_next.tmr_flags[TA_OVF_BIT];

        // Request is offered in the same cycle that the flag sets, which leaves
        // the core its stacking cycles within the four-cycle entry.
        s_next.req = s_next.gie && !s_next.hold && (pend != '0);
        s_next.vec = s_next.req ? pick_vector(pend) : VEC_NONE;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg       <= '0;
            s_reg.ready <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign hrdata        = s_reg.rdata;
    assign hreadyout     = s_reg.ready;
    assign hresp         = s_reg.resp;
    assign irq_req       = s_reg.req;
    assign irq_vector    = s_reg.vec;
    assign global_enable = s_reg.gie;

endmodule

// >>> verification/irq_ctrl_properties.sv
/* Concurrent checks on the interrupt controller's bus and core ports.
   Assumes it is bound into the controller and sees only its ports. */
`timescale 1ns/1ps
module irq_ctrl_properties (
    input wire logic                      hclk,
    input wire logic                      hresetn,
    input wire logic                      hsel,
    input wire logic [31:0]               haddr,
    input wire logic [1:0]                htrans,
    input wire logic                      hwrite,
    input wire logic                      hready,
    input wire logic [31:0]               hrdata,
    input wire logic                      hreadyout,
    input wire logic                      hresp,
    input wire logic                      instr_done,
    input wire logic                      irq_take,
    input wire logic                      return_from_handler_exec,
    input wire logic                      irq_req,
    input wire logic [irq_pkg::VEC_W-1:0] irq_vector,
    input wire logic                      global_enable
);
    import irq_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_unmapped_zero: assert property (hsel && hready && htrans[1]
        && !hwrite && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_take_clears_gie: assert property (irq_take
        |=> !global_enable && !irq_req)
        else $error("take left enable or request up");
    a_return_sets_gie: assert property (return_from_handler_exec && !irq_take
        |=> global_enable)
        else $error("return did not set enable");
    a_return_hold: assert property (return_from_handler_exec ##1 !instr_done
        |=> !irq_req)
        else $error("request before one more instruction");
    a_gie_gates_req: assert property (
        !global_enable && !$past(global_enable) |-> !irq_req)
        else $error("request while enable clear");
    a_vector_range: assert property (irq_req ?
        (irq_vector >= 4'h1 && irq_vector <= 4'h6) : irq_vector == VEC_NONE)
        else $error("vector out of range");
    c_take: cover property (irq_take);
    c_return: cover property (return_from_handler_exec ##2 instr_done);
    c_write: cover property (hsel && hready && htrans[1] && hwrite);
endmodule

bind irq_ctrl irq_ctrl_properties i_irq_ctrl_properties (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .instr_done(instr_done), .irq_take(irq_take),
    .return_from_handler_exec(return_from_handler_exec), .irq_req(irq_req),
    .irq_vector(irq_vector), .global_enable(global_enable));

// >>> verification/core_model.sv
/* Core model: takes offered vectors when allowed and plays returns.
   Assumes the controller's core-side ports on the same clock. */
`timescale 1ns/1ps
module core_model (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      irq_req,
    input  wire logic [irq_pkg::VEC_W-1:0] irq_vector,
    input  wire logic                      take_en,
    output logic                           irq_take,
    output logic                           instr_done,
    output logic                           return_from_handler_exec,
    output logic      [irq_pkg::VEC_W-1:0] last_vec,
    output int                             takes
);
    import irq_pkg::*;
    // Takes only an offered request, at an instruction boundary.
    // Holding take_en low plays a core stuck in a long instruction.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_take <= 1'b0;
            last_vec <= VEC_NONE;
            takes    <= 0;
        end else begin
            irq_take <= take_en && irq_req && !irq_take;
            if (irq_take) begin
                last_vec <= irq_vector;
                takes    <= takes + 1;
            end
        end
    end
    initial begin
        return_from_handler_exec  = 1'b0;
        instr_done = 1'b0;
    end
    // A return, then one main instruction before anything else.
    task automatic ret();
        @(posedge hclk) return_from_handler_exec <= 1'b1;
        @(posedge hclk) return_from_handler_exec <= 1'b0;
        @(posedge hclk) instr_done <= 1'b1;
        @(posedge hclk) instr_done <= 1'b0;
    endtask
endmodule

// >>> verification/irq_mask_flag_controller_tb.sv
/* Self-checking testbench for the interrupt mask and flag controller.
   Assumes the core model, the bound checker and the register package. */
`timescale 1ns/1ps
module irq_mask_flag_controller_tb;
    import irq_pkg::*;
    localparam logic [7:0] A_SEN = {2'b00, IDX_SENSE};
    localparam logic [7:0] A_TF  = {2'b00, IDX_TMR_FLAGS};
    localparam logic [7:0] A_TM  = {2'b00, IDX_TMR_MASK};
    localparam logic [7:0] A_PF  = {2'b00, IDX_PIN_FLAGS};
    localparam logic [7:0] A_PM  = {2'b00, IDX_PIN_MASK};
    localparam logic [7:0] A_ST  = {2'b00, IDX_STATUS};
    localparam logic [7:0] RA [7] = '{A_TF, A_TM, A_PF, A_PM, A_ST,
                                      A_SEN, 8'h40};
    localparam logic [7:0] RW [7] = '{8'h00, TMR_RW_MASK, 8'h00,
                                      PIN_RW_MASK, 8'h80, SENSE_RW_MASK,
                                      8'h00};
    logic             hclk, hresetn, hsel, hwrite, pin_a, pin_b, take_en;
    logic             irq_req, irq_take, instr_done, return_from_handler_exec;
    logic             hreadyout, hresp, global_enable;
    logic [31:0]      haddr, hwdata, hrdata, rd;
    logic [1:0]       htrans;
    logic [3:0]       tev;
    logic [VEC_W-1:0] irq_vector, last_vec;
    int               takes, mismatches, total_checks;

    irq_ctrl i_irq_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ext_pin_a(pin_a),
        .ext_pin_b(pin_b), .tmr_b_overflow_evt(tev[3]),
        .tmr_b_compare_evt(tev[2]), .tmr_b_capture_evt(tev[1]),
        .tmr_a_overflow_evt(tev[0]), .instr_done(instr_done),
        .irq_take(irq_take), .return_from_handler_exec(return_from_handler_exec), .irq_req(irq_req),
        .irq_vector(irq_vector), .global_enable(global_enable));
    core_model i_core_model (.hclk(hclk), .hresetn(hresetn),
        .irq_req(irq_req), .irq_vector(irq_vector), .take_en(take_en),
        .irq_take(irq_take), .instr_done(instr_done),
        .return_from_handler_exec(return_from_handler_exec), .last_vec(last_vec), .takes(takes));

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // One whole AHB single transfer; the data phase ends the task.
    task automatic xfer(input logic [7:0] i, input logic w,
                        input logic [7:0] d);
        haddr  <= {22'h0, i, 2'b00};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic rdc(input logic [7:0] i, input logic [7:0] e);
        xfer(i, 1'b0, 8'h00);
        chk($sformatf("reg %h", i), {24'h0, e}, rd);
    endtask
    task automatic take_chk(input logic [VEC_W-1:0] e);
        int n;
        n = takes;
        while (takes == n) @(posedge hclk);
        chk("vector", {28'h0, e}, {28'h0, last_vec});
        chk("enable", 32'h0, {31'h0, global_enable});
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Whole run is under two hundred cycles; this is ample margin.
    initial begin
        #100us;
        mismatches++;
        test_done();
    end
    initial begin
        {hsel, hwrite, pin_a, take_en, hresetn} = 5'b10000;
        pin_b  = 1'b1;
        haddr  = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        tev    = 4'h0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int k = 0; k < 7; k++) begin
            rdc(RA[k], REG_RESET);
            xfer(RA[k], 1'b1, 8'hFF);
            rdc(RA[k], RW[k]);
        end
        xfer(A_ST, 1'b1, 8'h00);
        xfer(A_PM, 1'b1, 8'h00);
        xfer(A_PF, 1'b1, PIN_RW_MASK);
        $display("test registers done");
        xfer(A_TM, 1'b1, TMR_RW_MASK);
        tev <= 4'hF;
        @(posedge hclk);
        tev <= 4'h0;
        rdc(A_TF, TMR_RW_MASK);
        take_en <= 1'b1;
        xfer(A_ST, 1'b1, 8'h80);
        for (int k = 0; k < 4; k++) begin
            take_chk(4'(k + 3));
            if (k == 0)
                xfer(A_ST, 1'b1, 8'h80);
            else
                i_core_model.ret();
        end
        rdc(A_TF, 8'h00);
        $display("test timer vectors done");
        xfer(A_SEN, 1'b1, 8'h0B);
        pin_a <= 1'b1;
        pin_b <= 1'b0;
        repeat (8) @(posedge hclk);
        rdc(A_PF, PIN_RW_MASK);
        xfer(A_PF, 1'b1, 8'h40);
        rdc(A_PF, 8'h80);
        xfer(A_PM, 1'b1, 8'h80);
        take_chk(4'h2);
        rdc(A_PF, 8'h00);
        i_core_model.ret();
        xfer(A_PM, 1'b1, 8'h00);
        xfer(A_SEN, 1'b1, 8'h04);
        pin_a <= 1'b0;
        pin_b <= 1'b1;
        repeat (8) @(posedge hclk);
        rdc(A_PF, 8'h80);
        xfer(A_PM, 1'b1, 8'h40);
        take_chk(4'h1);
        take_en <= 1'b0;
        pin_a <= 1'b1;
        i_core_model.ret();
        repeat (8) @(posedge hclk);
        chk("request", 32'h0, {31'h0, irq_req});
        $display("test pin vectors done");
        test_done();
    end
endmodule
